/* logic/cax_defs.svh */
`ifndef CAX_DEFS_SVH
`define CAX_DEFS_SVH
// apb register byte offsets
`define CAX_OFF_CMD      12'h000
`define CAX_OFF_ACCF     12'h004
`define CAX_OFF_BC       12'h008
`define CAX_OFF_DE       12'h00c
`define CAX_OFF_HL       12'h010
`define CAX_OFF_SP       12'h014
`define CAX_OFF_IX       12'h018
`define CAX_OFF_IY       12'h01c
`define CAX_OFF_PC       12'h020
`define CAX_OFF_SHADOW   12'h024
`define CAX_OFF_MEMLO    12'h028
`define CAX_OFF_MEMHI    12'h02c
`define CAX_OFF_STATUS   12'h030
`define CAX_OFF_RESULT   12'h034
// flag bit positions
`define CAX_F_S   7
`define CAX_F_Z   6
`define CAX_F_H   4
`define CAX_F_PV  2
`define CAX_F_N   1
`define CAX_F_C   0
// opcode fields and execute constants
`define CAX_PREFIX_IX   8'hdd
`define CAX_PREFIX_IY   8'hfd
`define CAX_OP_DEC_IDX  8'h2b
`define CAX_OP_EX_STACK 8'he3
`define CAX_PC_REWIND   16'h0002
`define CAX_DEC_PV_VAL  8'h80
// clock states per instruction
`define CAX_T_CMP_REP   5'd16
`define CAX_T_ONE       5'd4
`define CAX_T_DEC_IDX   5'd10
`define CAX_T_DEC_PAIR  5'd6
`define CAX_T_EX_HL     5'd19
`define CAX_T_EX_IDX    5'd23
`endif

/* logic/cax_pkg.sv */
package cax_pkg;
  typedef enum logic [3:0] {
    CAX_OP_CMP_REP  = 4'h0,
    CAX_OP_CPL      = 4'h1,
    CAX_OP_DAA      = 4'h2,
    CAX_OP_DEC_R    = 4'h3,
    CAX_OP_DEC_SS   = 4'h4,
    CAX_OP_DEC_IX   = 4'h5,
    CAX_OP_DEC_IY   = 4'h6,
    CAX_OP_DI       = 4'h7,
    CAX_OP_EI       = 4'h8,
    CAX_OP_EX_AF    = 4'h9,
    CAX_OP_EX_DEHL  = 4'ha,
    CAX_OP_EX_SPHL  = 4'hb,
    CAX_OP_EX_SPIX  = 4'hc
  } cax_op_e;
  typedef enum logic [1:0] {
    CAX_IDLE = 2'b01,
    CAX_BUSY = 2'b10
  } cax_state_e;
endpackage : cax_pkg

/* logic/cax_core.sv */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "cax_defs.svh"
module cax_core (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_req_n,
  output logic             irq_taken
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0]         af_q, af_d;
  logic [15:0]         afs_q, afs_d;
  logic [15:0]         bc_q, bc_d;
  logic [15:0]         de_q, de_d;
  logic [15:0]         hl_q, hl_d;
  logic [15:0]         sp_q, sp_d;
  logic [15:0]         ix_q, ix_d;
  logic [15:0]         iy_q, iy_d;
  logic [15:0]         pc_q, pc_d;
  logic [7:0]          mlo_q, mlo_d;
  logic [7:0]          mhi_q, mhi_d;
  logic [7:0]          res_q, res_d;
  logic [4:0]          tcnt_q, tcnt_d;
  logic                ff1_q, ff1_d;
  logic                ff2_q, ff2_d;
  logic                ei_blk_q, ei_blk_d;
  logic                done_q, done_d;
  logic [11:0]         cmd_q, cmd_d;
  cax_pkg::cax_state_e st_q, st_d;
  logic                irq_s1_q, irq_s2_q;
  logic                wr, rd_ok;

  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_ok;

  function automatic logic [15:0] rd16(input logic [31:0] d);
    rd16 = d[15:0];
  endfunction : rd16

  function automatic logic parity_even(input logic [7:0] v);
    parity_even = ~^v;
  endfunction : parity_even

  ////////////////////////////////////////////////////////////////////////////
  // execute: cmd fields [3:0] op, [6:4] r field, [8:7] ss, [9] daa after sub
  logic [7:0]  acc, flg, dec_src, dec_res, cmp_res, daa_fix, daa_res;
  logic        daa_c, cnt_nz, match, lo_big, hi_big;
  logic [15:0] bc_dec;
  logic [4:0]  tlen;

  always_comb
  begin
    acc = af_q[15:8];
    flg = af_q[7:0];
    unique case (cmd_q[6:4])
      3'b000:  dec_src = bc_q[15:8];
      3'b001:  dec_src = bc_q[7:0];
      3'b010:  dec_src = de_q[15:8];
      3'b011:  dec_src = de_q[7:0];
      3'b100:  dec_src = hl_q[15:8];
      3'b101:  dec_src = hl_q[7:0];
      default: dec_src = acc;
    endcase
    dec_res = dec_src - 8'h01;
    cmp_res = acc - mlo_q;
    bc_dec  = bc_q - 16'h0001;
    cnt_nz  = (bc_dec != 16'h0000);
    match   = (acc == mlo_q);
    lo_big  = (acc[3:0] > 4'h9);
    hi_big  = (acc[7:4] > 4'h9);
    daa_c   = flg[`CAX_F_C];
    if (!cmd_q[9])
    begin
      daa_fix = {((daa_c || hi_big || (acc[7:4] == 4'h9 && lo_big)) ? 4'h6 : 4'h0),
                 ((flg[`CAX_F_H] || lo_big) ? 4'h6 : 4'h0)};
      daa_c   = daa_fix[7:4] != 4'h0;
    end
    else
    begin
      unique case ({flg[`CAX_F_C], flg[`CAX_F_H]})
        2'b01:   daa_fix = 8'hfa;
        2'b10:   daa_fix = 8'ha0;
        2'b11:   daa_fix = 8'h9a;
        default: daa_fix = 8'h00;
      endcase
    end
    daa_res = acc + daa_fix;
    unique case (cax_pkg::cax_op_e'(cmd_q[3:0]))
      cax_pkg::CAX_OP_CMP_REP: tlen = `CAX_T_CMP_REP;
      cax_pkg::CAX_OP_DEC_IX,
      cax_pkg::CAX_OP_DEC_IY:  tlen = `CAX_T_DEC_IDX;
      cax_pkg::CAX_OP_DEC_SS:  tlen = `CAX_T_DEC_PAIR;
      cax_pkg::CAX_OP_EX_SPHL: tlen = `CAX_T_EX_HL;
      cax_pkg::CAX_OP_EX_SPIX: tlen = `CAX_T_EX_IDX;
      default:                 tlen = `CAX_T_ONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    af_d     = af_q;
    afs_d    = afs_q;
    bc_d     = bc_q;
    de_d     = de_q;
    hl_d     = hl_q;
    sp_d     = sp_q;
    ix_d     = ix_q;
    iy_d     = iy_q;
    pc_d     = pc_q;
    mlo_d    = mlo_q;
    mhi_d    = mhi_q;
    res_d    = res_q;
    cmd_d    = cmd_q;
    ff1_d    = ff1_q;
    ff2_d    = ff2_q;
    ei_blk_d = ei_blk_q;
    done_d   = done_q;
    tcnt_d   = tcnt_q;
    st_d     = st_q;
    unique case (st_q)
      cax_pkg::CAX_IDLE:
      begin
        if (wr && paddr == `CAX_OFF_CMD)
        begin
          cmd_d  = pwdata[11:0];
          tcnt_d = 5'd1;
          done_d = 1'b0;
          st_d   = cax_pkg::CAX_BUSY;
          ei_blk_d = (cax_pkg::cax_op_e'(pwdata[3:0]) == cax_pkg::CAX_OP_EI);
        end
        else if (wr)
        begin
          unique case (paddr)
            `CAX_OFF_ACCF:   af_d  = rd16(pwdata);
            `CAX_OFF_BC:     bc_d  = rd16(pwdata);
            `CAX_OFF_DE:     de_d  = rd16(pwdata);
            `CAX_OFF_HL:     hl_d  = rd16(pwdata);
            `CAX_OFF_SP:     sp_d  = rd16(pwdata);
            `CAX_OFF_IX:     ix_d  = rd16(pwdata);
            `CAX_OFF_IY:     iy_d  = rd16(pwdata);
            `CAX_OFF_PC:     pc_d  = rd16(pwdata);
            `CAX_OFF_SHADOW: afs_d = rd16(pwdata);
            `CAX_OFF_MEMLO:  mlo_d = pwdata[7:0];
            `CAX_OFF_MEMHI:  mhi_d = pwdata[7:0];
            default: ;
          endcase
        end
      end
      cax_pkg::CAX_BUSY:
      begin
        // results commit on the last clock state so timing is visible
        tcnt_d = tcnt_q + 5'd1;
        if (tcnt_q == tlen)
        begin
          st_d     = cax_pkg::CAX_IDLE;
          done_d   = 1'b1;
          ei_blk_d = 1'b0;
          unique case (cax_pkg::cax_op_e'(cmd_q[3:0]))
            cax_pkg::CAX_OP_CMP_REP:
            begin
              res_d = cmp_res;
              bc_d  = bc_dec;
              hl_d  = hl_q + 16'h0001;
              af_d[`CAX_F_S]  = cmp_res[7];
              af_d[`CAX_F_Z]  = match;
              af_d[`CAX_F_H]  = acc[3:0] < mlo_q[3:0];
              af_d[`CAX_F_PV] = cnt_nz;
              af_d[`CAX_F_N]  = 1'b1;
              if (cnt_nz && !match)
                pc_d = pc_q - `CAX_PC_REWIND;
            end
            cax_pkg::CAX_OP_CPL:
            begin
              af_d[15:8]      = ~acc;
              af_d[`CAX_F_H]  = 1'b1;
              af_d[`CAX_F_N]  = 1'b1;
            end
            cax_pkg::CAX_OP_DAA:
            begin
              af_d[15:8]      = daa_res;
              af_d[`CAX_F_C]  = daa_c;
              af_d[`CAX_F_S]  = daa_res[7];
              af_d[`CAX_F_Z]  = daa_res == 8'h00;
              af_d[`CAX_F_PV] = parity_even(daa_res);
              af_d[`CAX_F_H]  = cmd_q[9] ? (flg[`CAX_F_H] && acc[3:0] < 4'h6) : lo_big;
            end
            cax_pkg::CAX_OP_DEC_R:
            begin
              res_d = dec_res;
              unique case (cmd_q[6:4])
                3'b000:  bc_d[15:8] = dec_res;
                3'b001:  bc_d[7:0]  = dec_res;
                3'b010:  de_d[15:8] = dec_res;
                3'b011:  de_d[7:0]  = dec_res;
                3'b100:  hl_d[15:8] = dec_res;
                3'b101:  hl_d[7:0]  = dec_res;
                default: af_d[15:8] = dec_res;
              endcase
              af_d[`CAX_F_S]  = dec_res[7];
              af_d[`CAX_F_Z]  = dec_res == 8'h00;
              af_d[`CAX_F_H]  = dec_src[3:0] == 4'h0;
              af_d[`CAX_F_PV] = dec_src == `CAX_DEC_PV_VAL;
              af_d[`CAX_F_N]  = 1'b1;
            end
            cax_pkg::CAX_OP_DEC_SS:
            begin
              unique case (cmd_q[8:7])
                2'b00:   bc_d = bc_q - 16'h0001;
                2'b01:   de_d = de_q - 16'h0001;
                2'b10:   hl_d = hl_q - 16'h0001;
                default: sp_d = sp_q - 16'h0001;
              endcase
            end
            cax_pkg::CAX_OP_DEC_IX: ix_d = ix_q - 16'h0001;
            cax_pkg::CAX_OP_DEC_IY: iy_d = iy_q - 16'h0001;
            cax_pkg::CAX_OP_DI:
            begin
              ff1_d = 1'b0;
              ff2_d = 1'b0;
            end
            cax_pkg::CAX_OP_EI:
            begin
              ff1_d = 1'b1;
              ff2_d = 1'b1;
            end
            cax_pkg::CAX_OP_EX_AF:
            begin
              af_d  = afs_q;
              afs_d = af_q;
            end
            cax_pkg::CAX_OP_EX_DEHL:
            begin
              de_d = hl_q;
              hl_d = de_q;
            end
            cax_pkg::CAX_OP_EX_SPHL:
            begin
              hl_d  = {mhi_q, mlo_q};
              mlo_d = hl_q[7:0];
              mhi_d = hl_q[15:8];
            end
            cax_pkg::CAX_OP_EX_SPIX:
            begin
              if (cmd_q[10])
              begin
                iy_d  = {mhi_q, mlo_q};
                mlo_d = iy_q[7:0];
                mhi_d = iy_q[15:8];
              end
              else
              begin
                ix_d  = {mhi_q, mlo_q};
                mlo_d = ix_q[7:0];
                mhi_d = ix_q[15:8];
              end
            end
            default: ;
          endcase
        end
      end
      default: st_d = cax_pkg::CAX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // maskable request: synchronised, honoured only when enabled and not in ei
  logic irq_d;
  assign irq_d = !irq_s2_q && ff1_q && !ei_blk_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      af_q      <= 16'h0000;
      afs_q     <= 16'h0000;
      bc_q      <= 16'h0000;
      de_q      <= 16'h0000;
      hl_q      <= 16'h0000;
      sp_q      <= 16'h0000;
      ix_q      <= 16'h0000;
      iy_q      <= 16'h0000;
      pc_q      <= 16'h0000;
      mlo_q     <= 8'h00;
      mhi_q     <= 8'h00;
      res_q     <= 8'h00;
      cmd_q     <= 12'h000;
      tcnt_q    <= 5'd0;
      st_q      <= cax_pkg::CAX_IDLE;
      ff1_q     <= 1'b0;
      ff2_q     <= 1'b0;
      ei_blk_q  <= 1'b0;
      done_q    <= 1'b0;
      // idle level of the request pin, so no false request follows reset
      irq_s1_q  <= 1'b1;
      irq_s2_q  <= 1'b1;
      irq_taken <= 1'b0;
    end
    else
    begin
      af_q      <= af_d;
      afs_q     <= afs_d;
      bc_q      <= bc_d;
      de_q      <= de_d;
      hl_q      <= hl_d;
      sp_q      <= sp_d;
      ix_q      <= ix_d;
      iy_q      <= iy_d;
      pc_q      <= pc_d;
      mlo_q     <= mlo_d;
      mhi_q     <= mhi_d;
      res_q     <= res_d;
      cmd_q     <= cmd_d;
      tcnt_q    <= tcnt_d;
      st_q      <= st_d;
      ff1_q     <= ff1_d;
      ff2_q     <= ff2_d;
      ei_blk_q  <= ei_blk_d;
      done_q    <= done_d;
      irq_s1_q  <= irq_req_n;
      irq_s2_q  <= irq_s1_q;
      irq_taken <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    rd_ok  = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      `CAX_OFF_CMD:    prdata = {20'h00000, cmd_q};
      `CAX_OFF_ACCF:   prdata = {16'h0000, af_q};
      `CAX_OFF_BC:     prdata = {16'h0000, bc_q};
      `CAX_OFF_DE:     prdata = {16'h0000, de_q};
      `CAX_OFF_HL:     prdata = {16'h0000, hl_q};
      `CAX_OFF_SP:     prdata = {16'h0000, sp_q};
      `CAX_OFF_IX:     prdata = {16'h0000, ix_q};
      `CAX_OFF_IY:     prdata = {16'h0000, iy_q};
      `CAX_OFF_PC:     prdata = {16'h0000, pc_q};
      `CAX_OFF_SHADOW: prdata = {16'h0000, afs_q};
      `CAX_OFF_MEMLO:  prdata = {24'h000000, mlo_q};
      `CAX_OFF_MEMHI:  prdata = {24'h000000, mhi_q};
      `CAX_OFF_STATUS: prdata = {27'h0000000, ei_blk_q, ff2_q, ff1_q, done_q,
                                 st_q == cax_pkg::CAX_BUSY};
      `CAX_OFF_RESULT: prdata = {24'h000000, res_q};
      default:         rd_ok  = 1'b0;
    endcase
  end
endmodule : cax_core

/* tb/cax_irq_src.sv */
`timescale 1ns/1ns
module cax_irq_src (
  input  wire logic clock,
  input  wire logic want,
  output logic      irq_req_n
);
  logic req_d;
  // level request, changed only on a clock edge like a real requester
  always_comb
  begin
    req_d = !want;
  end
  always_ff @(posedge clock)
  begin
    irq_req_n <= req_d;
  end
endmodule : cax_irq_src

/* tb/cax_core_asserts.sv */
`timescale 1ns/1ns
module cax_core_asserts (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_req_n,
  input wire logic        irq_taken
);
  logic [4:0] cnt_q, cnt_d, t_n;
  logic [3:0] op_q, op_d;
  logic       ff_q, ff_d, ran_q, ran_d, ld, wr_cmd, rd_st;
  assign wr_cmd = psel & penable & pready & pwrite & (paddr == 12'h000);
  assign rd_st  = psel & penable & pready & !pwrite & (paddr == 12'h030);
  //////////////////////////////
  // a command while busy is dropped, so only load when idle
  always_comb
  begin
    ld = wr_cmd & (cnt_q == 5'h00);
    case (pwdata[3:0])
      4'h0: t_n = 5'h10;
      4'h4: t_n = 5'h06;
      4'h5, 4'h6: t_n = 5'h0a;
      4'hb: t_n = 5'h13;
      4'hc: t_n = 5'h17;
      default: t_n = 5'h04;
    endcase
    cnt_d = ld ? t_n : ((cnt_q != 5'h00) ? cnt_q - 5'h01 : 5'h00);
    op_d  = ld ? pwdata[3:0] : op_q;
    ran_d = ran_q | ld;
    ff_d  = (ld & (pwdata[3:0] == 4'h8)) | (ff_q & !(ld & (pwdata[3:0] == 4'h7)));
  end
  always_ff @(posedge clock)
  begin
    cnt_q <= nrst ? cnt_d : 5'h00;
    op_q  <= nrst ? op_d : 4'h0;
    ran_q <= nrst & ran_d;
    ff_q  <= nrst & ff_d;
  end
  //////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence ei_cmd;
    ld && pwdata[3:0] == 4'h8;
  endsequence
  sequence di_cmd;
    ld && pwdata[3:0] == 4'h7;
  endsequence
  busy_on_a: assert property (rd_st && cnt_q > 5'h01 |-> prdata[0])
    else $error("status idle while instruction runs");
  done_a: assert property (rd_st && cnt_q == 5'h00 && ran_q |-> prdata[1:0] == 2'b10)
    else $error("status not done after instruction");
  ff_pair_a: assert property (rd_st && cnt_q == 5'h00 |-> prdata[3:2] == {2{ff_q}})
    else $error("enable flip-flops wrong");
  ei_running_a: assert property (rd_st && cnt_q > 5'h01 && op_q == 4'h8 |-> prdata[4])
    else $error("enable op not flagged running");
  ei_blocked_a: assert property (ei_cmd |=> ##1 (!irq_taken)[*3])
    else $error("request taken during enable op");
  ei_honours_a: assert property (ei_cmd ##1 (!irq_req_n)[*8] |-> ##[0:3] irq_taken)
    else $error("request not honoured after enable");
  di_blocks_a: assert property (di_cmd |-> ##7 (!irq_taken)[*2])
    else $error("request taken after disable");
  req_drop_a: assert property ((irq_req_n)[*4] |=> !irq_taken)
    else $error("taken without a request");
endmodule : cax_core_asserts
bind cax_core cax_core_asserts i_chk (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq_req_n(irq_req_n), .irq_taken(irq_taken));

/* tb/tb_cax_core.sv */
`timescale 1ns/1ns
module tb_cax_core;
  typedef struct {logic [15:0] ai; logic [31:0] cmd; logic [15:0] ex; logic [15:0] m;} cax_row_s;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, irq_req_n, irq_taken, want;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  int          n_fail, samples_checked;
  // a in 15:8, f in 7:0; h masked out of decimal adjust
  cax_row_s rows [10] = '{
    '{16'hb4c5, 32'h1, 16'h4bd7, 16'hffd7}, '{16'h3c00, 32'h2, 16'h4204, 16'hffc7},
    '{16'h1501, 32'h2, 16'h7501, 16'hffc7}, '{16'h9a00, 32'h2, 16'h0045, 16'hffc7},
    '{16'ha210, 32'h2, 16'h0801, 16'hffc7}, '{16'h0f12, 32'h202, 16'h0906, 16'hffc7},
    '{16'hf503, 32'h202, 16'h9587, 16'hffc7}, '{16'h6613, 32'h202, 16'h0047, 16'hffc7},
    '{16'h8001, 32'h73, 16'h7f17, 16'hffd7}, '{16'h0100, 32'h73, 16'h0042, 16'hffd7}};
  cax_core i_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req_n(irq_req_n), .irq_taken(irq_taken));
  cax_irq_src i_src (.clock(clock), .want(want), .irq_req_n(irq_req_n));
  always #5 clock = !clock;
  //////////////////////////////
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic cmp(input string s, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      $display("[ERR] %s expected %h seen %h", s, x, g);
      n_fail++;
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      cmp("pready", 32'h1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), x & m, q & m);
  endtask : rc
  // no fixed latency is assumed; poll until the core reports idle
  task automatic op(input logic [31:0] c);
    int n;
    apb(1'b1, 12'h000, c);
    n = 0;
    do
    begin
      apb(1'b0, 12'h030, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    cmp("busy", 32'h0, {31'h0, q[0]});
  endtask : op
  //////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rc(12'h030, 32'h0);
    rc(12'h004, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, 12'h004, {16'h0, rows[i].ai});
      op(rows[i].cmd);
      rc(12'h004, {16'h0, rows[i].ex}, {16'h0, rows[i].m});
    end
    apb(1'b1, 12'h008, 32'h1020);
    apb(1'b1, 12'h00c, 32'h3040);
    apb(1'b1, 12'h010, 32'h5060);
    for (int r = 0; r < 6; r++)
      op(32'h3 | 32'(r << 4));
    apb(1'b1, 12'h004, 32'h00ff);
    apb(1'b1, 12'h014, 32'h0);
    for (int s = 0; s < 4; s++)
      op(32'h4 | 32'(s << 7));
    rc(12'h008, 32'h0f1e);
    rc(12'h00c, 32'h2f3e);
    rc(12'h010, 32'h4f5e);
    rc(12'h014, 32'hffff);
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b1, 12'h01c, 32'h7649);
    op(32'h5);
    op(32'h6);
    rc(12'h018, 32'hffff);
    rc(12'h01c, 32'h7648);
    op(32'ha);
    rc(12'h00c, 32'h4f5e);
    rc(12'h010, 32'h2f3e);
    apb(1'b1, 12'h010, 32'h7012);
    apb(1'b1, 12'h014, 32'h8856);
    apb(1'b1, 12'h028, 32'h11);
    apb(1'b1, 12'h02c, 32'h22);
    op(32'hb);
    rc(12'h010, 32'h2211);
    rc(12'h028, 32'h12);
    rc(12'h02c, 32'h70);
    apb(1'b1, 12'h018, 32'h3988);
    apb(1'b1, 12'h028, 32'h80);
    apb(1'b1, 12'h02c, 32'h48);
    op(32'hc);
    rc(12'h018, 32'h4880);
    op(32'h40c);
    rc(12'h01c, 32'h3988);
    rc(12'h028, 32'h48);
    rc(12'h02c, 32'h76);
    rc(12'h014, 32'h8856);
    rc(12'h004, 32'h00ff);
    apb(1'b1, 12'h004, 32'h9900);
    apb(1'b1, 12'h024, 32'h5944);
    op(32'h9);
    rc(12'h004, 32'h5944);
    rc(12'h024, 32'h9900);
    apb(1'b1, 12'h004, 32'hf301);
    apb(1'b1, 12'h010, 32'h1111);
    apb(1'b1, 12'h008, 32'h0007);
    apb(1'b1, 12'h020, 32'h0200);
    apb(1'b1, 12'h028, 32'h52);
    op(32'h0);
    rc(12'h004, 32'hf387, 32'hffd7);
    rc(12'h008, 32'h0006);
    rc(12'h010, 32'h1112);
    rc(12'h034, 32'ha1);
    rc(12'h020, 32'h01fe);
    apb(1'b1, 12'h028, 32'hf3);
    op(32'h0);
    rc(12'h004, 32'hf347, 32'hffd7);
    rc(12'h008, 32'h0005);
    rc(12'h020, 32'h01fe);
    want <= 1'b1;
    op(32'h7);
    repeat (6) @(posedge clock);
    cmp("irq_taken", 32'h0, {31'h0, irq_taken});
    op(32'h8);
    repeat (6) @(posedge clock);
    cmp("irq_taken", 32'h1, {31'h0, irq_taken});
    op(32'h7);
    repeat (6) @(posedge clock);
    cmp("irq_taken", 32'h0, {31'h0, irq_taken});
    want <= 1'b0;
    apb(1'b0, 12'h040, 32'h0);
    cmp("slverr", 32'h1, {31'h0, e});
    cmp("unmapped", 32'h0, q);
    print_verdict();
  end
endmodule : tb_cax_core
